// [design/tbd_decoder.sv]
// Texture block decoder: one texel per request, tile position and image size.
// Assumes the fetch unit presents a whole tile with the texel coordinates and
// that the sampler may stall the result stream at any time.

module tbd_decoder
(
  input logic core_clk,
  input logic srst,
  input logic inValid,
  output logic inReady,
  input tbd_pkg::tbd_format_t inFormat,
  input logic [tbd_pkg::TILE_BITS-1:0] inTile,
  input logic [tbd_pkg::DIM_BITS-1:0] inWidth,
  input logic [tbd_pkg::DIM_BITS-1:0] inHeight,
  input logic [tbd_pkg::DIM_BITS-1:0] inX,
  input logic [tbd_pkg::DIM_BITS-1:0] inY,
  output logic outValid,
  input logic outReady,
  output logic signed [tbd_pkg::VALUE_BITS-1:0] outRed,
  output logic signed [tbd_pkg::VALUE_BITS-1:0] outGreen,
  output logic signed [tbd_pkg::VALUE_BITS-1:0] outBlue,
  output logic signed [tbd_pkg::VALUE_BITS-1:0] outAlpha,
  output logic [tbd_pkg::OFFSET_BITS-1:0] outTileOffset,
  output logic [tbd_pkg::OFFSET_BITS-1:0] outImageBytes
);
  import tbd_pkg::*;

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------

  // Decodes one 64-bit half for the texel at index 4y+x.
  // The divisor takes only six constant values, so synthesis builds a small
  // table of constant dividers rather than a general divider.
  function automatic logic signed [VALUE_BITS-1:0] decodeChannel
  (
    input logic [HALF_BITS-1:0] half,
    input logic isSigned,
    input logic [3:0] texel
  );
    logic signed [9:0] ev0;
    logic signed [9:0] ev1;
    logic [2:0] code;
    logic sixStep;
    int wa;
    int wb;
    int den;
    int scale;
    int num;
    logic signed [VALUE_BITS-1:0] result;
    ev0 = isSigned ? 10'(signed'(half[7:0])) : signed'({2'h0, half[7:0]});
    ev1 = isSigned ? 10'(signed'(half[ENDPOINT1_LSB +: 8]))
                   : signed'({2'h0, half[ENDPOINT1_LSB +: 8]});
    // Comparison uses the raw bytes; -127 against -128 therefore picks six steps.
    sixStep = isSigned ? (signed'(half[7:0]) > signed'(half[ENDPOINT1_LSB +: 8]))
                       : (half[7:0] > half[ENDPOINT1_LSB +: 8]);
    if (isSigned && half[7:0] == SIGNED_FLOOR_RAW)
    begin
      ev0 = SIGNED_FLOOR_CLAMP;
    end
    if (isSigned && half[ENDPOINT1_LSB +: 8] == SIGNED_FLOOR_RAW)
    begin
      ev1 = SIGNED_FLOOR_CLAMP;
    end
    code = half[INDEX_LSB + CODE_BITS * int'(texel) +: CODE_BITS];
    scale = isSigned ? SIGNED_SCALE : UNSIGNED_SCALE;
    wa = 0;
    wb = 0;
    den = 1;
    result = VALUE_ZERO;
    if (code == 3'h0)
    begin
      wa = 1;
    end
    else if (code == 3'h1)
    begin
      wb = 1;
    end
    else if (sixStep)
    begin
      wa = SEVEN_STEP_DEN + 1 - int'(code);
      wb = int'(code) - 1;
      den = SEVEN_STEP_DEN;
    end
    else if (code < CODE_MIN)
    begin
      wa = FIVE_STEP_DEN + 1 - int'(code);
      wb = int'(code) - 1;
      den = FIVE_STEP_DEN;
    end
    num = wa * int'(ev0) + wb * int'(ev1);
    result = VALUE_BITS'((num * VALUE_ONE_INT) / (den * scale));
    if (!sixStep && code == CODE_MIN)
    begin
      result = isSigned ? VALUE_MINUS_ONE : VALUE_ZERO;
    end
    if (!sixStep && code == CODE_MAX)
    begin
      result = VALUE_ONE;
    end
    return result;
  endfunction : decodeChannel

  logic isSigned;
  logic isTwo;
  logic [3:0] texelIndex;
  logic signed [VALUE_BITS-1:0] decoded [CHANNELS];

  assign isSigned = (inFormat == SIGNED_ONE_CHANNEL_FORMAT)
                 || (inFormat == SIGNED_TWO_CHANNEL_FORMAT);
  assign isTwo = (inFormat == UNSIGNED_TWO_CHANNEL_FORMAT)
              || (inFormat == SIGNED_TWO_CHANNEL_FORMAT);
  // Low two bits of each coordinate are the position inside the tile.
  assign texelIndex = {inY[1:0], inX[1:0]};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_channel
      // Half zero is red, half one is green; both follow the same rules.
      assign decoded[ch] = decodeChannel(inTile[ch * HALF_BITS +: HALF_BITS],
                                         isSigned, texelIndex);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Tile position and image size
  // ----------------------------------------------------------------

  logic [OFFSET_BITS-1:0] tileBytes;
  logic [DIM_BITS:0] tilesAcross;
  logic [DIM_BITS:0] tilesDown;
  logic [OFFSET_BITS-1:0] tileOffset;
  logic [OFFSET_BITS-1:0] imageBytes;

  // Edge tiles are counted whole; texels past the edge are don't-care.
  assign tileBytes = isTwo ? TILE_BYTES_TWO : TILE_BYTES_ONE;
  assign tilesAcross = ({1'b0, inWidth} + TILE_ROUND_UP) >> TILE_SHIFT;
  assign tilesDown = ({1'b0, inHeight} + TILE_ROUND_UP) >> TILE_SHIFT;
  assign tileOffset = OFFSET_BITS'(tileBytes * (OFFSET_BITS'(tilesAcross)
                    * OFFSET_BITS'(inY >> TILE_SHIFT)
                    + OFFSET_BITS'(inX >> TILE_SHIFT)));
  assign imageBytes = OFFSET_BITS'(OFFSET_BITS'(tilesAcross)
                    * OFFSET_BITS'(tilesDown) * tileBytes);

  // ----------------------------------------------------------------
  // Decode stage register
  // ----------------------------------------------------------------

  logic s1Valid_reg;
  logic signed [VALUE_BITS-1:0] s1Red_reg;
  logic signed [VALUE_BITS-1:0] s1Green_reg;
  logic [OFFSET_BITS-1:0] s1Offset_reg;
  logic [OFFSET_BITS-1:0] s1Bytes_reg;
  tbd_format_t s1Format_reg;
  logic bufInReady;
  logic accept;
  logic push;
  logic pop;

  // The stage may load whenever it is empty or moves into the buffer.
  assign inReady = !s1Valid_reg || bufInReady;
  assign accept = inValid && inReady;
  assign push = s1Valid_reg && bufInReady;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s1Valid_reg <= 1'b0;
    end
    else if (accept)
    begin
      s1Valid_reg <= 1'b1;
    end
    else if (push)
    begin
      s1Valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s1Red_reg <= VALUE_ZERO;
      s1Green_reg <= VALUE_ZERO;
      s1Offset_reg <= '0;
      s1Bytes_reg <= '0;
      s1Format_reg <= UNSIGNED_ONE_CHANNEL_FORMAT;
    end
    else if (accept)
    begin
      s1Red_reg <= decoded[0];
      s1Green_reg <= isTwo ? decoded[1] : VALUE_ZERO;
      s1Offset_reg <= tileOffset;
      s1Bytes_reg <= imageBytes;
      s1Format_reg <= inFormat;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry result buffer
  // ----------------------------------------------------------------

  logic signed [VALUE_BITS-1:0] bufRed_reg [BUF_DEPTH];
  logic signed [VALUE_BITS-1:0] bufGreen_reg [BUF_DEPTH];
  logic [OFFSET_BITS-1:0] bufOffset_reg [BUF_DEPTH];
  logic [OFFSET_BITS-1:0] bufBytes_reg [BUF_DEPTH];
  logic wrPtr_reg;
  logic rdPtr_reg;
  logic [1:0] count_reg;

  assign bufInReady = (count_reg != 2'(BUF_DEPTH));
  assign outValid = (count_reg != 2'h0);
  assign pop = outValid && outReady;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      wrPtr_reg <= wrPtr_reg ^ push;
      rdPtr_reg <= rdPtr_reg ^ pop;
      count_reg <= count_reg + 2'(push) - 2'(pop);
    end
  end

  // Storage has no reset; the count alone decides what is valid.
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      bufRed_reg[wrPtr_reg] <= s1Red_reg;
      bufGreen_reg[wrPtr_reg] <= s1Green_reg;
      bufOffset_reg[wrPtr_reg] <= s1Offset_reg;
      bufBytes_reg[wrPtr_reg] <= s1Bytes_reg;
    end
  end

  assign outRed = outValid ? bufRed_reg[rdPtr_reg] : VALUE_ZERO;
  assign outGreen = outValid ? bufGreen_reg[rdPtr_reg] : VALUE_ZERO;
  assign outTileOffset = outValid ? bufOffset_reg[rdPtr_reg] : '0;
  assign outImageBytes = outValid ? bufBytes_reg[rdPtr_reg] : '0;
  assign outBlue = VALUE_ZERO;
  assign outAlpha = VALUE_ONE;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  logic firstTexel;
  assign firstTexel = (texelIndex == 4'h0);

  sequence seqTake;
    inValid && inReady;
  endsequence

  sequence seqUnsignedCode0Top;
    inFormat == UNSIGNED_ONE_CHANNEL_FORMAT && firstTexel
    && inTile[7:0] == 8'hFF && inTile[INDEX_LSB +: CODE_BITS] == 3'h0;
  endsequence

  // The code is taken at the requested texel, so every texel of a tile can trip it.
  sequence seqSignedFourStep(logic [2:0] c);
    inFormat == SIGNED_ONE_CHANNEL_FORMAT
    && signed'(inTile[7:0]) <= signed'(inTile[ENDPOINT1_LSB +: 8])
    && inTile[INDEX_LSB + CODE_BITS * int'(texelIndex) +: CODE_BITS] == c;
  endsequence

  sequence seqTakeEmpty;
    seqTake ##0 (!s1Valid_reg && count_reg == 2'h0);
  endsequence

  take_latency_a: assert property (seqTake |=> s1Valid_reg)
    else $error("Taken request did not reach the decode stage.");

  buf_bound_a: assert property (count_reg <= 2'(BUF_DEPTH))
    else $error("Result buffer count exceeded its depth.");

  stall_hold_a: assert property (
    outValid && !outReady |=> outValid && $stable(outRed) && $stable(outTileOffset))
    else $error("Stalled result changed or vanished.");

  const_channels_a: assert property (
    outValid |-> outBlue == VALUE_ZERO && outAlpha == VALUE_ONE)
    else $error("Blue or alpha channel not constant.");

  one_green_a: assert property (
    s1Valid_reg && (s1Format_reg == UNSIGNED_ONE_CHANNEL_FORMAT
    || s1Format_reg == SIGNED_ONE_CHANNEL_FORMAT) |-> s1Green_reg == VALUE_ZERO)
    else $error("One-channel result has nonzero green.");

  unsigned_range_a: assert property (
    s1Valid_reg && (s1Format_reg == UNSIGNED_ONE_CHANNEL_FORMAT
    || s1Format_reg == UNSIGNED_TWO_CHANNEL_FORMAT)
    |-> s1Red_reg >= VALUE_ZERO && s1Red_reg <= VALUE_ONE)
    else $error("Unsigned red out of range.");

  signed_range_a: assert property (
    s1Valid_reg |-> s1Red_reg >= VALUE_MINUS_ONE && s1Red_reg <= VALUE_ONE)
    else $error("Red value outside minus one to one.");

  offset_align_a: assert property (
    s1Valid_reg |-> s1Offset_reg[2:0] == 3'h0
    && (s1Format_reg == UNSIGNED_ONE_CHANNEL_FORMAT
    || s1Format_reg == SIGNED_ONE_CHANNEL_FORMAT || s1Offset_reg[3] == 1'b0))
    else $error("Tile offset not aligned to the tile size.");

  size_cover_a: assert property (
    seqTake ##1 s1Valid_reg |-> s1Bytes_reg == $past(imageBytes) && s1Bytes_reg[2:0] == 3'h0)
    else $error("Image size wrong or not whole tiles.");

  endpoint_a: assert property (seqTake and seqUnsignedCode0Top |=> s1Red_reg == VALUE_ONE)
    else $error("Code zero did not return the first endpoint.");

  signed_min_a: assert property (
    seqTake and seqSignedFourStep(CODE_MIN) |=> s1Red_reg == VALUE_MINUS_ONE)
    else $error("Signed code six did not give minus one.");

  signed_max_a: assert property (
    seqTake and seqSignedFourStep(CODE_MAX) |=> s1Red_reg == VALUE_ONE)
    else $error("Signed code seven did not give one.");

  // A refused request must not cost the stage the result it already holds.
  refuse_keep_a: assert property (
    inValid && !inReady |=> s1Valid_reg && $stable(s1Red_reg) && $stable(s1Offset_reg))
    else $error("Stage lost its result while a request was refused.");

  empty_latency_a: assert property (seqTakeEmpty |=> !outValid ##1 outValid)
    else $error("Result from an empty pipeline was not ready two edges after taking.");

  green_range_a: assert property (
    s1Valid_reg && s1Format_reg == UNSIGNED_TWO_CHANNEL_FORMAT
    |-> s1Green_reg >= VALUE_ZERO && s1Green_reg <= VALUE_ONE)
    else $error("Unsigned green out of range.");

endmodule : tbd_decoder

// [design/tbd_pkg.sv]
// Constants and types shared by the texture block decoder.
// Assumes a single 20 MHz clock and a synchronous, active-high reset.
//
// What this block does
// - Image is a grid of 4x4 tiles of 64 or 128 bits each.
// - Texels beyond the image edge are decoded but carry no defined meaning.
// - Image bytes equal tiles across times tiles down times tile size.
// - Tile offset is tile size times (tiles across times y/4 plus x/4).
// - Texel inside its tile is addressed at (x mod 4, y mod 4).
// - A 64-bit half holds two endpoint bytes then six index bytes.
// - Index bytes form one 48-bit little-endian vector.
// - Unsigned formats read endpoint bytes as unsigned integers.
// - Texel code is vector bits 3*(4y+x)+2 down to 3*(4y+x).
// - Endpoint order picks six sevenths steps or four fifths steps.
// - In the four-step mode codes 6 and 7 give minimum and maximum.
// - One-channel formats output (R, 0, 0, 1).
// - Signed formats read endpoint bytes as two's complement for compare and value.
// - Signed endpoint is value over 127, with -128 giving -1.0.
// - Mode for endpoints -127 and -128 may go either way.
// - Unsigned two-channel tile: first half is red, second half green.
// - Signed two-channel tile decodes both halves with signed rules.
// - Two-channel formats output (R, G, 0, 1).
// - The requester picks one of four formats and decoding follows it.

package tbd_pkg;

  typedef enum logic [1:0]
  {
    UNSIGNED_ONE_CHANNEL_FORMAT = 2'h0,
    SIGNED_ONE_CHANNEL_FORMAT = 2'h1,
    UNSIGNED_TWO_CHANNEL_FORMAT = 2'h2,
    SIGNED_TWO_CHANNEL_FORMAT = 2'h3
  } tbd_format_t;

  localparam int DIM_BITS = 16;
  localparam int OFFSET_BITS = 32;
  localparam int TILE_BITS = 128;
  localparam int HALF_BITS = 64;
  localparam int CHANNELS = 2;
  localparam int TILE_SHIFT = 2;
  localparam int CODE_BITS = 3;
  localparam int INDEX_LSB = 16;
  localparam int ENDPOINT1_LSB = 8;
  localparam int VALUE_BITS = 16;
  localparam int BUF_DEPTH = 2;

  localparam logic [OFFSET_BITS-1:0] TILE_BYTES_ONE = 32'h0000_0008;
  localparam logic [OFFSET_BITS-1:0] TILE_BYTES_TWO = 32'h0000_0010;
  localparam logic [DIM_BITS:0] TILE_ROUND_UP = 17'h0_0003;

  // Channel values are signed fixed point with 14 fraction bits.
  localparam logic signed [VALUE_BITS-1:0] VALUE_ONE = 16'sh4000;
  localparam logic signed [VALUE_BITS-1:0] VALUE_MINUS_ONE = 16'shC000;
  localparam logic signed [VALUE_BITS-1:0] VALUE_ZERO = 16'sh0000;
  localparam int VALUE_ONE_INT = 16384;
  localparam int UNSIGNED_SCALE = 255;
  localparam int SIGNED_SCALE = 127;
  localparam logic [7:0] SIGNED_FLOOR_RAW = 8'h80;
  localparam logic signed [9:0] SIGNED_FLOOR_CLAMP = 10'sh381;
  localparam logic [2:0] CODE_MIN = 3'h6;
  localparam logic [2:0] CODE_MAX = 3'h7;
  localparam int SEVEN_STEP_DEN = 7;
  localparam int FIVE_STEP_DEN = 5;

endpackage : tbd_pkg

// [bench/tbd_sampler_model.sv]
// Sampler model that takes decoded texels from the decoder's result stream.
// Assumes one clock shared with the decoder and a bench that steers stalls.
module tbd_sampler_model
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic outValid,
  output logic outReady,
  input wire logic signed [tbd_pkg::VALUE_BITS-1:0] outRed,
  input wire logic signed [tbd_pkg::VALUE_BITS-1:0] outGreen,
  input wire logic signed [tbd_pkg::VALUE_BITS-1:0] outBlue,
  input wire logic signed [tbd_pkg::VALUE_BITS-1:0] outAlpha,
  input wire logic [tbd_pkg::OFFSET_BITS-1:0] outTileOffset,
  input wire logic [tbd_pkg::OFFSET_BITS-1:0] outImageBytes
);
  timeunit 1ns;
  timeprecision 1ps;
  import tbd_pkg::*;

  // Every accepted result in arrival order, read back by the bench.
  logic [127:0] gotQ[$];

  // Ready follows the stall request one edge late, as a real sampler would.
  // Ready is unknown only until the first edge, which always falls in reset.
  always @(posedge core_clk)
  begin
    outReady <= !stall && !srst;
    if (!srst && outValid && outReady)
    begin
      gotQ.push_back({outRed, outGreen, outBlue, outAlpha, outTileOffset, outImageBytes});
    end
  end
endmodule : tbd_sampler_model

// [bench/tb_top.sv]
// Self-checking bench for the texture block decoder.
// Assumes the sampler model sits on the result side and the bench is the fetch unit.
`define CHK(nm, ex, got) \
  begin testsRun++; if ((got) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tbd_pkg::*;

  logic core_clk, srst, inValid, outReady, outValid, inReady, stall;
  tbd_format_t inFormat;
  logic [127:0] inTile;
  logic [15:0] inWidth, inHeight, inX, inY;
  logic signed [15:0] outRed, outGreen, outBlue, outAlpha;
  logic [31:0] outTileOffset, outImageBytes;
  int mismatches = 0;
  int testsRun = 0;
  logic [127:0] expQ[$];

  tbd_decoder dut_u (.core_clk(core_clk), .srst(srst), .inValid(inValid), .inReady(inReady),
    .inFormat(inFormat), .inTile(inTile), .inWidth(inWidth), .inHeight(inHeight), .inX(inX),
    .inY(inY), .outValid(outValid), .outReady(outReady), .outRed(outRed),
    .outGreen(outGreen), .outBlue(outBlue), .outAlpha(outAlpha),
    .outTileOffset(outTileOffset), .outImageBytes(outImageBytes));

  tbd_sampler_model sinkU (.core_clk(core_clk), .srst(srst), .stall(stall),
    .outValid(outValid), .outReady(outReady), .outRed(outRed), .outGreen(outGreen),
    .outBlue(outBlue), .outAlpha(outAlpha), .outTileOffset(outTileOffset),
    .outImageBytes(outImageBytes));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Reference value of one texel from one 64-bit half.
  function automatic logic signed [15:0] expv(logic [63:0] h, bit sg, int t);
    int e0, e1, c, sc, wa, wb, den;
    bit six;
    e0 = sg ? int'($signed(h[7:0])) : int'(h[7:0]);
    e1 = sg ? int'($signed(h[15:8])) : int'(h[15:8]);
    c = int'(h[16+3*t +: 3]);
    sc = sg ? 127 : 255;
    six = e0 > e1;
    if (e0 == -128) e0 = -127;
    if (e1 == -128) e1 = -127;
    if (c == 0) return 16'(e0 * 16384 / sc);
    if (c == 1) return 16'(e1 * 16384 / sc);
    if (!six && c == 6) return sg ? 16'shC000 : 16'sh0000;
    if (!six && c == 7) return 16'sh4000;
    wa = six ? 8 - c : 6 - c;
    wb = c - 1;
    den = six ? 7 : 5;
    return 16'((wa * e0 + wb * e1) * 16384 / (den * sc));
  endfunction : expv

  function automatic logic [63:0] mkhalf(logic [7:0] e0, logic [7:0] e1, int m, int a);
    logic [63:0] v;
    v = {48'h0000_0000_0000, e1, e0};
    for (int t = 0; t < 16; t++) v[16+3*t +: 3] = 3'((m * t + a) % 8);
    return v;
  endfunction : mkhalf

  // Presents one request, holds it until taken, and records the reference result.
  task automatic send(tbd_format_t f, logic [127:0] tl, int w, int h, int x, int y);
    int n, t, tb, ac;
    logic signed [15:0] r, g;
    inValid <= 1'b1;
    inFormat <= f;
    inTile <= tl;
    inWidth <= 16'(w);
    inHeight <= 16'(h);
    inX <= 16'(x);
    inY <= 16'(y);
    t = 4 * (y % 4) + x % 4;
    tb = f[1] ? 16 : 8;
    ac = (w + 3) / 4;
    r = expv(tl[63:0], f[0], t);
    g = f[1] ? expv(tl[127:64], f[0], t) : 16'sh0000;
    expQ.push_back({r, g, 16'sh0000, 16'sh4000, 32'(tb * (ac * (y / 4) + x / 4)),
      32'(ac * ((h + 3) / 4) * tb)});
    n = 0;
    @(negedge core_clk);
    while (inReady !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (inReady !== 1'b1)
      mismatches++;
    @(posedge core_clk);
  endtask : send

  task automatic idle();
    inValid <= 1'b0;
  endtask : idle

  task automatic drain();
    int n;
    logic [127:0] e, s;
    n = 0;
    while (sinkU.gotQ.size() < expQ.size() && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK("result count", expQ.size(), sinkU.gotQ.size())
    while (expQ.size() > 0 && sinkU.gotQ.size() > 0)
    begin
      e = expQ.pop_front();
      s = sinkU.gotQ.pop_front();
      `CHK("result", e, s)
    end
  endtask : drain

  task automatic check_reset();
    @(negedge core_clk);
    `CHK("inReady in reset", 1'b1, inReady)
    `CHK("outValid in reset", 1'b0, outValid)
    `CHK("alpha in reset", 16'sh4000, outAlpha)
    @(posedge core_clk);
    srst <= 1'b0;
  endtask : check_reset

  // Every format, both interpolation modes, every code and every texel of a tile.
  task automatic decode_all();
    // Pattern two breaks the encoder advice on purpose, to pin the chosen mode.
    logic [7:0] pe0 [4] = '{8'hC8, 8'h20, 8'h81, 8'hFF};
    logic [7:0] pe1 [4] = '{8'h10, 8'hE0, 8'h80, 8'h00};
    logic [127:0] tl;
    for (int f = 0; f < 4; f++)
      for (int p = 0; p < 4; p++)
      begin
        tl = {mkhalf(pe1[p], pe0[p], 5, 1), mkhalf(pe0[p], pe1[p], 3, 0)};
        for (int t = 0; t < 16; t++)
          send(tbd_format_t'(f), tl, 13, 9, 4 * p + t % 4, 4 * (f % 3) + t / 4);
      end
    idle();
    drain();
  endtask : decode_all

  task automatic latency();
    send(SIGNED_TWO_CHANNEL_FORMAT, {2{mkhalf(8'h80, 8'h7F, 7, 2)}}, 4, 4, 3, 3);
    idle();
    @(negedge core_clk);
    `CHK("outValid one cycle after", 1'b0, outValid)
    @(negedge core_clk);
    `CHK("outValid two cycles after", 1'b1, outValid)
    drain();
  endtask : latency

  // Capacity is three results; inReady must drop while stalled, and a fourth sent after the stall ends must arrive without loss.
  task automatic backpressure();
    stall <= 1'b1;
    for (int i = 0; i < 3; i++)
      send(UNSIGNED_ONE_CHANNEL_FORMAT, {64'h0, mkhalf(8'h40, 8'hF0, 1, i)}, 16, 16, i, 5);
    idle();
    repeat (4) @(negedge core_clk);
    `CHK("inReady when full", 1'b0, inReady)
    `CHK("outValid held in stall", 1'b1, outValid)
    @(posedge core_clk);
    stall <= 1'b0;
    send(UNSIGNED_TWO_CHANNEL_FORMAT, {2{mkhalf(8'h05, 8'hFA, 3, 4)}}, 17, 3, 16, 2);
    idle();
    drain();
  endtask : backpressure

  task automatic summarize();
    if (mismatches == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    srst = 1'b1;
    inValid = 1'b0;
    stall = 1'b0;
    inFormat = UNSIGNED_ONE_CHANNEL_FORMAT;
    inTile = 128'h0;
    inWidth = 16'h0000;
    inHeight = 16'h0000;
    inX = 16'h0000;
    inY = 16'h0000;
    repeat (15) @(posedge core_clk);
    check_reset();
    @(posedge core_clk);
    decode_all();
    latency();
    backpressure();
    summarize();
  end

  // A hang is cut off well past the three hundred or so cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
endmodule : tb_top
